// ---- hdl/orng_detector.sv ----
`timescale 1ns/1ps
module orng_detector
	import orng_pkg::*;
#(
	parameter int SAMPLE_W = 16
)(
	input  wire logic                ref_clk,
	input  wire logic                arst_n,
	input  wire logic                clk_en,
	input  wire logic                sample_valid,
	input  wire logic [SAMPLE_W-1:0] chan_a_i,
	input  wire logic [SAMPLE_W-1:0] chan_a_q,
	input  wire logic [SAMPLE_W-1:0] chan_b_i,
	input  wire logic [SAMPLE_W-1:0] chan_b_q,
	input  wire logic [ADDR_W-1:0]   reg_addr,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	input  wire logic [DATA_W-1:0]   reg_wdata,
	output logic      [DATA_W-1:0]   reg_rdata,
	output logic                     reg_rvalid,
	output logic      [1:0]          link_flag_a,
	output logic      [1:0]          link_flag_b,
	output logic                     chan_a_flag_zero_pin,
	output logic                     chan_a_flag_one_pin,
	output logic                     chan_b_flag_zero_pin,
	output logic                     chan_b_flag_one_pin
);

	import orng_pkg::*;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [DATA_W-1:0] level_limit_zero_q;
	logic [DATA_W-1:0] level_limit_one_q;
	logic [DATA_W-1:0] level_pin_config_q;
	logic [DATA_W-1:0] reg_rdata_d;

	wire hit_zero   = (reg_addr == LIMIT_ZERO_ADDR);
	wire hit_one    = (reg_addr == LIMIT_ONE_ADDR);
	wire hit_config = (reg_addr == PIN_CONFIG_ADDR);

	wire                     level_pin_enable       = level_pin_config_q[PIN_ENABLE_BIT];
	wire [STRETCH_EXP_W-1:0] pulse_stretch_exponent =
		level_pin_config_q[STRETCH_EXP_LSB +: STRETCH_EXP_W];

	orng_access_t access;
	assign access = reg_wr ? ORNG_WRITE : (reg_rd ? ORNG_READ : ORNG_IDLE);

	always_comb begin
		reg_rdata_d = reg_rdata;
		case (access)
			ORNG_READ: begin
				reg_rdata_d = hit_zero   ? level_limit_zero_q :
				              hit_one    ? level_limit_one_q  :
				              hit_config ? level_pin_config_q : '0;
			end
			ORNG_WRITE: reg_rdata_d = reg_rdata;
			ORNG_IDLE:  reg_rdata_d = reg_rdata;
			default:    reg_rdata_d = '0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			level_limit_zero_q <= LIMIT_ZERO_RST;
			level_limit_one_q  <= LIMIT_ONE_RST;
			level_pin_config_q <= PIN_CONFIG_RST;
		end else if (clk_en && access == ORNG_WRITE) begin
			if (hit_zero) begin
				level_limit_zero_q <= reg_wdata;
			end
			if (hit_one) begin
				level_limit_one_q <= reg_wdata;
			end
			if (hit_config) begin
				level_pin_config_q <= reg_wdata;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata  <= '0;
			reg_rvalid <= 1'b0;
		end else if (clk_en) begin
			reg_rdata  <= reg_rdata_d;
			reg_rvalid <= (access == ORNG_READ);
		end
	end

	// ----------------------------------------
	// magnitude compare, one per sample stream
	// ----------------------------------------
	localparam int PAD_W = SAMPLE_W - 1 - FULL_SCALE_LOG2;

	logic [SAMPLE_W-1:0] samples [4];
	logic [3:0]          detect;
	logic [3:0]          pins_q;

	assign samples[0] = chan_a_i;
	assign samples[1] = chan_a_q;
	assign samples[2] = chan_b_i;
	assign samples[3] = chan_b_q;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			wire [SAMPLE_W-1:0] magnitude = samples[g][SAMPLE_W-1] ?
				SAMPLE_W'(~samples[g] + SAMPLE_W'(1)) : samples[g];
			// even lanes are I on limit zero, odd lanes are Q on limit one
			wire [DATA_W-1:0]   limit     = (g % 2 == 0) ? level_limit_zero_q : level_limit_one_q;
			// full scale is 2^(W-1), limit/256 of that
			wire [SAMPLE_W-1:0] level     = {1'b0, limit, {PAD_W{1'b0}}};
			assign detect[g] = sample_valid && (magnitude >= level);

			orng_stretch u_stretch (
				.ref_clk     (ref_clk),
				.arst_n      (arst_n),
				.clk_en      (clk_en),
				.pin_enable  (level_pin_enable),
				.stretch_exp (pulse_stretch_exponent),
				.detect      (detect[g]),
				.pin_q       (pins_q[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// link flags, not gated by pin enable
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			link_flag_a <= 2'h0;
			link_flag_b <= 2'h0;
		end else if (clk_en && sample_valid) begin
			link_flag_a <= detect[1:0];
			link_flag_b <= detect[3:2];
		end
	end

	assign chan_a_flag_zero_pin = pins_q[0];
	assign chan_a_flag_one_pin  = pins_q[1];
	assign chan_b_flag_zero_pin = pins_q[2];
	assign chan_b_flag_one_pin  = pins_q[3];

endmodule

// ---- hdl/orng_pkg.sv ----
package orng_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int          ADDR_W          = 15;
	localparam int          DATA_W          = 8;
	localparam logic [14:0] LIMIT_ZERO_ADDR = 15'h0211;
	localparam logic [14:0] LIMIT_ONE_ADDR  = 15'h0212;
	localparam logic [14:0] PIN_CONFIG_ADDR = 15'h0213;

	localparam logic [7:0]  LIMIT_ZERO_RST  = 8'hf2;
	localparam logic [7:0]  LIMIT_ONE_RST   = 8'hab;
	localparam logic [7:0]  PIN_CONFIG_RST  = 8'h07;

	// ----------------------------------------
	// pin config fields
	// ----------------------------------------
	localparam int          PIN_ENABLE_BIT  = 3;
	localparam int          STRETCH_EXP_LSB = 0;
	localparam int          STRETCH_EXP_W   = 3;

	// ----------------------------------------
	// level scaling and pulse timing
	// ----------------------------------------
	localparam int          FULL_SCALE_LOG2 = 8;
	localparam int          STRETCH_BASE    = 8;
	localparam int          STRETCH_MAX_EXP = 7;
	localparam int          STRETCH_CNT_W   = $clog2(STRETCH_BASE << STRETCH_MAX_EXP) + 1;

	typedef enum logic [1:0] {
		ORNG_IDLE,
		ORNG_WRITE,
		ORNG_READ
	} orng_access_t;

endpackage

// ---- hdl/orng_stretch.sv ----
`timescale 1ns/1ps
module orng_stretch
	import orng_pkg::*;
(
	input  wire logic                     ref_clk,
	input  wire logic                     arst_n,
	input  wire logic                     clk_en,
	input  wire logic                     pin_enable,
	input  wire logic [STRETCH_EXP_W-1:0] stretch_exp,
	input  wire logic                     detect,
	output logic                          pin_q
);

	logic [STRETCH_CNT_W-1:0] cnt_q;
	logic [STRETCH_CNT_W-1:0] cnt_d;
	logic                     pin_d;
	wire  [STRETCH_CNT_W-1:0] pulse_len;
	wire                      busy;

	// ----------------------------------------
	// length 8 << exponent, counted in clocks
	// ----------------------------------------
	assign pulse_len = STRETCH_CNT_W'(STRETCH_BASE) << stretch_exp;
	assign busy      = (cnt_q != '0);

	always_comb begin
		cnt_d = cnt_q;
		pin_d = pin_q;
		if (!pin_enable) begin
			cnt_d = '0;
			pin_d = 1'b0;
		end else if (detect) begin
			cnt_d = pulse_len - STRETCH_CNT_W'(1);
			pin_d = 1'b1;
		end else if (busy) begin
			cnt_d = cnt_q - STRETCH_CNT_W'(1);
			pin_d = 1'b1;
		end else begin
			pin_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
			pin_q <= 1'b0;
		end else if (clk_en) begin
			cnt_q <= cnt_d;
			pin_q <= pin_d;
		end
	end

endmodule

// ---- sim/orng_monitor.sv ----
`timescale 1ns/1ps
module orng_monitor
	import orng_pkg::*;
#(
	parameter int SAMPLE_W = 16
)(
	input wire logic                ref_clk,
	input wire logic                arst_n,
	input wire logic                clk_en,
	input wire logic                sample_valid,
	input wire logic [SAMPLE_W-1:0] chan_a_i,
	input wire logic [ADDR_W-1:0]   reg_addr,
	input wire logic                reg_wr,
	input wire logic                reg_rd,
	input wire logic [DATA_W-1:0]   reg_wdata,
	input wire logic                reg_rvalid,
	input wire logic [1:0]          link_flag_a,
	input wire logic                chan_a_flag_zero_pin,
	input wire logic                chan_b_flag_one_pin
);
	logic en_q;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// pin enable as last written
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			en_q <= 1'b0;
		end else if (clk_en && reg_wr && reg_addr == PIN_CONFIG_ADDR) begin
			en_q <= reg_wdata[PIN_ENABLE_BIT];
		end
	end
	read_cause_a: assert property (reg_rvalid && $past(clk_en) |-> $past(reg_rd && !reg_wr))
		else $error("stray rvalid");
	pin_off_a: assert property (!en_q |=> !chan_a_flag_zero_pin && !chan_b_flag_one_pin)
		else $error("pin high while off");
	link_full_a: assert property (clk_en && sample_valid && chan_a_i == {1'b1, {(SAMPLE_W-1){1'b0}}}
		|=> link_flag_a[0]) else $error("full scale missed");
	link_hold_a: assert property (!(clk_en && sample_valid) |=> $stable(link_flag_a))
		else $error("flag moved");
	pin_cause_a: assert property ($rose(chan_a_flag_zero_pin) |-> link_flag_a[0])
		else $error("pin without detect");
	stretch_zero_a: assert property ($rose(chan_a_flag_zero_pin) |-> (chan_a_flag_zero_pin || !en_q)[*8])
		else $error("short pulse");
	stretch_one_a: assert property ($rose(chan_b_flag_one_pin) |-> (chan_b_flag_one_pin || !en_q)[*8])
		else $error("short pulse");
	freeze_a: assert property (!clk_en |=> $stable(reg_rvalid) && $stable(chan_a_flag_zero_pin))
		else $error("moved while frozen");
endmodule

// ---- sim/orng_pin_watch.sv ----
`timescale 1ns/1ps
module orng_pin_watch (
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        pin,
	output logic      [11:0] width_q
);
	logic [11:0] run_q;
	// length of the last high run of the pin
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			run_q   <= 12'h000;
			width_q <= 12'h000;
		end else if (pin) begin
			run_q <= run_q + 12'h001;
		end else if (run_q != 12'h000) begin
			width_q <= run_q;
			run_q   <= 12'h000;
		end
	end
endmodule

// ---- sim/orng_detector_test.sv ----
`timescale 1ns/1ps
module orng_detector_test;
	import orng_pkg::*;
	logic        ref_clk, arst_n, clk_en, sample_valid, reg_wr, reg_rd, reg_rvalid;
	logic        chan_a_flag_zero_pin, chan_a_flag_one_pin, chan_b_flag_zero_pin, chan_b_flag_one_pin;
	logic [15:0] chan_a_i, chan_a_q, chan_b_i, chan_b_q;
	logic [14:0] reg_addr;
	logic [7:0]  reg_wdata, reg_rdata;
	logic [1:0]  link_flag_a, link_flag_b;
	logic [11:0] wa, wb;
	int          fail_count, check_count, cyc;
	logic [15:0] lvl [6] = '{16'h1fff, 16'h2000, 16'he000, 16'he001, 16'h2080, 16'hdf80};
	logic [1:0]  hit [6] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h3, 2'h3};
	logic [2:0]  ex [4]  = '{3'h0, 3'h1, 3'h2, 3'h7};
	orng_detector u_dut (.ref_clk, .arst_n, .clk_en, .sample_valid, .chan_a_i, .chan_a_q, .chan_b_i, .chan_b_q,
		.reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .link_flag_a, .link_flag_b,
		.chan_a_flag_zero_pin, .chan_a_flag_one_pin, .chan_b_flag_zero_pin, .chan_b_flag_one_pin);
	orng_pin_watch u_wa (.ref_clk, .arst_n, .pin(chan_a_flag_zero_pin), .width_q(wa));
	orng_pin_watch u_wb (.ref_clk, .arst_n, .pin(chan_b_flag_one_pin), .width_q(wb));
	always #12.5 ref_clk = ~ref_clk;
	task automatic final_report;
		$display("checks=%0d mismatches=%0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			final_report;
		end
	end
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [14:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk({3'h0, reg_rvalid, reg_rdata}, {4'h1, e});
	endtask
	task automatic samp(input logic [15:0] ai, input logic [15:0] aq, input logic [15:0] bq);
		@(posedge ref_clk);
		sample_valid <= 1'b1;
		chan_a_i     <= ai;
		chan_a_q     <= aq;
		chan_b_i     <= aq;
		chan_b_q     <= bq;
		@(posedge ref_clk);
		sample_valid <= 1'b0;
		#1;
	endtask
	initial begin
		{ref_clk, arst_n, sample_valid, reg_wr, reg_rd, reg_addr, reg_wdata, cyc} = '0;
		{chan_a_i, chan_a_q, chan_b_i, chan_b_q, fail_count, check_count} = '0;
		clk_en = 1'b1;
		repeat (8) @(posedge ref_clk);
		arst_n <= 1'b1;
		rd(LIMIT_ZERO_ADDR, LIMIT_ZERO_RST);
		rd(LIMIT_ONE_ADDR, LIMIT_ONE_RST);
		rd(PIN_CONFIG_ADDR, PIN_CONFIG_RST);
		@(posedge ref_clk);
		clk_en <= 1'b0;
		wr(LIMIT_ZERO_ADDR, 8'h00);
		clk_en <= 1'b1;
		wr(15'h0214, 8'hff);
		rd(15'h0214, 8'h00);
		rd(LIMIT_ZERO_ADDR, LIMIT_ZERO_RST);
		samp(16'h8000, 16'h8000, 16'h8000);
		chk({10'h0, link_flag_a}, 12'h003);
		chk({8'h0, chan_a_flag_zero_pin, chan_a_flag_one_pin, chan_b_flag_zero_pin, chan_b_flag_one_pin}, 12'h0);
		wr(LIMIT_ZERO_ADDR, 8'h40);
		wr(LIMIT_ONE_ADDR, 8'h41);
		foreach (lvl[i]) begin
			samp(lvl[i], lvl[i], lvl[i]);
			chk({8'h0, link_flag_b, link_flag_a}, {8'h0, hit[i], hit[i]});
		end
		foreach (ex[i]) begin
			wr(PIN_CONFIG_ADDR, {5'h01, ex[i]});
			samp(16'h2000, 16'h0000, 16'h7fff);
			chk({10'h0, chan_a_flag_one_pin, chan_b_flag_zero_pin}, 12'h000);
			repeat ((8 << ex[i]) + 4) @(posedge ref_clk);
			chk(wa, 12'h008 << ex[i]);
			chk(wb, 12'h008 << ex[i]);
		end
		wr(PIN_CONFIG_ADDR, 8'h08);
		samp(16'h2000, 16'h0000, 16'h0000);
		samp(16'h2000, 16'h0000, 16'h0000);
		repeat (16) @(posedge ref_clk);
		chk(wa, 12'h00a);
		samp(16'h0000, 16'h7fff, 16'h0000);
		chk({8'h0, chan_a_flag_zero_pin, chan_a_flag_one_pin, chan_b_flag_zero_pin, chan_b_flag_one_pin}, 12'h006);
		wr(PIN_CONFIG_ADDR, 8'h0f);
		samp(16'h2000, 16'h0000, 16'h0000);
		repeat (20) @(posedge ref_clk);
		wr(PIN_CONFIG_ADDR, 8'h07);
		@(posedge ref_clk);
		#1;
		chk({11'h0, chan_a_flag_zero_pin}, 12'h000);
		final_report;
	end
endmodule
bind orng_detector orng_monitor #(.SAMPLE_W(SAMPLE_W)) u_mon (.ref_clk, .arst_n, .clk_en, .sample_valid,
	.chan_a_i, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rvalid, .link_flag_a, .chan_a_flag_zero_pin,
	.chan_b_flag_one_pin);
